// >>> hdl/usaf_top.sv
// Purpose: Auxiliary pins, status outputs and buffer flow control.
// Assumes: USB side signals come from logic on clk; pins are asynchronous.
// Notes:   Send and interrupt inputs are active high; outputs active as named.
// Behaviour
// - Transmit indicator on 100 ms per send.
// - Receive indicator on 100 ms per arrival.
// - Combined indicator on 100 ms for either.
// - Configured output high once configured, also suspended.
// - Suspend output low while host sleeps.
// - Host-ready high once host application runs, configured and not suspended.
// - Low-power high while limited to 100 mA.
// - Go output low only configured, not suspended.
// - Status outputs follow the state encoding table.
// - Not-full drops at 16 free, returns at 32.
// - Bytes stored while any space remains.
// - Bytes into a full buffer are dropped.
// - Empty flag low on entry, high at last.
// - Send active: forward at 63 bytes or deselect.
// - Send inactive: hold bytes, start no new report.
// - Send rising: interrupt and forward at once.
// - General outputs reset inactive, set by command.
// - Interrupt pin rising gives one report.
// - Write lock ignores non-volatile setting writes.
// - Filler byte configurable, resets to all ones.
// - Filler loaded when empty is always sent.
// - Power source setting; sense reported when both.
// - Max bus power resets to 100 mA.
// - Four clock modes, default idle-high rising sample.
`timescale 1ns/10ps
`include "usaf_map.svh"
module usaf_top #(
  parameter int RX_DEPTH   = `USAF_RX_DEPTH,
  parameter int TX_DEPTH   = `USAF_TX_DEPTH,
  parameter int IND_CYCLES = `USAF_IND_MS * (`USAF_CLK_HZ / 1000)
) (
  input  wire logic                                    clk,
  input  wire logic                                    sys_rst,
  input  wire logic                                    sck_pin,
  input  wire logic                                    mosi_pin,
  input  wire logic                                    ss_n_pin,
  output logic                                         miso_o,
  output logic                                         miso_oe,
  input  wire logic                                    host_data_valid,
  input  wire logic [7:0]                              host_data,
  output logic                                         host_data_ready,
  output logic                                         usb_rpt_valid,
  output logic [7:0]                                   usb_rpt_data,
  output logic                                         usb_rpt_last,
  input  wire logic                                    usb_rpt_ready,
  input  wire logic                                    usb_configured,
  input  wire logic                                    usb_suspended,
  input  wire logic                                    unpowered_hub_state,
  input  wire logic                                    host_app_running,
  input  wire usaf_pkg::usaf_func_t [`USAF_NPINS-1:0]  aux_func,
  input  wire logic [`USAF_NPINS-1:0]                  aux_pin_i,
  output logic [`USAF_NPINS-1:0]                       aux_pin_o,
  output logic [`USAF_NPINS-1:0]                       aux_pin_oe,
  output logic [`USAF_NPINS-1:0]                       pin_levels,
  input  wire logic                                    gpo_set_valid,
  input  wire logic [3:0]                              gpo_set_idx,
  input  wire logic                                    gpo_set_level,
  output logic                                         int_report,
  input  wire logic                                    nv_wr_valid,
  input  wire usaf_pkg::usaf_nv_sel_t                  nv_wr_sel,
  input  wire logic [7:0]                              nv_wr_data,
  output logic                                         write_lock,
  output logic [1:0]                                   spi_mode,
  output logic [7:0]                                   filler_byte,
  output usaf_pkg::usaf_pwr_src_t                      power_src,
  output logic [7:0]                                   max_bus_power,
  output logic                                         self_power_rpt
);
  import usaf_pkg::*;
  localparam int NP = `USAF_NPINS;
  localparam int RW = $clog2(RX_DEPTH);
  localparam int TW = $clog2(TX_DEPTH);
  localparam logic [RW:0] RX_FULL = (RW + 1)'(RX_DEPTH);
  localparam logic [TW:0] TX_FULL = (TW + 1)'(TX_DEPTH);
  localparam logic [RW:0] LOW_W = (RW + 1)'(`USAF_LOW_WATER);
  localparam logic [RW:0] HIGH_W = (RW + 1)'(`USAF_HIGH_WATER);
  localparam logic [RW:0] RPT_N = (RW + 1)'(`USAF_REPORT_BYTES);

  // Whole control state of the block; the two byte stores sit beside it.
  typedef struct packed {
    logic [NP-1:0] meta;      // First synchroniser stage of the pins.
    logic [NP-1:0] sync;      // Second stage, the only copy logic reads.
    logic [NP-1:0] gpo;       // Levels of general-purpose outputs.
    logic [NP-1:0] pin_o;     // Registered pin drive values.
    logic [NP-1:0] pin_oe;    // Registered pin enables.
    logic [RW-1:0] rx_wr, rx_rd;
    logic [RW:0]   rx_cnt;
    logic [TW-1:0] tx_wr, tx_rd;
    logic [TW:0]   tx_cnt;
    logic          not_full;  // Receive-not-full with hysteresis.
    logic          send_prev, intr_prev;
    logic          pend;      // Deselect or send edge still to be served.
    logic [RW:0]   fwd_left;  // Bytes left in the report being sent.
    logic          int_rpt;
    logic          lock;
    logic [1:0]    mode;
    logic [7:0]    filler, maxp;
    usaf_pwr_src_t psrc;
    logic          cfg, susp_n, lowp, asg_n, hrdy;
  } usaf_st_t;
  usaf_st_t r, n;

  logic [7:0]    rx_mem [RX_DEPTH];  // Bytes from the master toward the host.
  logic [7:0]    tx_mem [TX_DEPTH];  // Bytes from the host toward the master.
  logic          tx_take, rx_valid, frame_end;
  logic [7:0]    rx_byte;
  logic          rx_push, rx_pop, tx_push, tx_pop;
  logic          tx_ind, rx_ind, txrx_ind;
  logic          send_on, send_rise, intr_rise, self_sense;
  logic [RW:0]   rx_free;
  logic [NP-1:0] pin_val, pin_en;

  // Serial slave port; the mode setting selects the clock edges.
  usaf_spi_slave u_spi (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .sck_pin   (sck_pin),
    .mosi_pin  (mosi_pin),
    .ss_n_pin  (ss_n_pin),
    .cpol      (r.mode[1]),
    .cpha      (r.mode[0]),
    .tx_have   (r.tx_cnt != '0),
    .tx_byte   (tx_mem[r.tx_rd]),
    .filler    (r.filler),
    .tx_take   (tx_take),
    .rx_valid  (rx_valid),
    .rx_byte   (rx_byte),
    .frame_end (frame_end),
    .miso_o    (miso_o),
    .miso_oe   (miso_oe)
  );

  // Three activity indicators, each restarted by its own events.
  usaf_ind_pulse #(.CYCLES(IND_CYCLES)) u_tx_ind (
    .clk(clk), .sys_rst(sys_rst), .trig(rx_pop), .ind(tx_ind));
  usaf_ind_pulse #(.CYCLES(IND_CYCLES)) u_rx_ind (
    .clk(clk), .sys_rst(sys_rst), .trig(tx_push), .ind(rx_ind));
  usaf_ind_pulse #(.CYCLES(IND_CYCLES)) u_txrx_ind (
    .clk(clk), .sys_rst(sys_rst), .trig(rx_pop | tx_push), .ind(txrx_ind));

  // Buffer handshakes; a full receive store simply refuses the byte.
  assign rx_push = rx_valid && (r.rx_cnt != RX_FULL);
  assign rx_pop = usb_rpt_valid && usb_rpt_ready;
  assign host_data_ready = (r.tx_cnt != TX_FULL);
  assign tx_push = host_data_valid && host_data_ready;
  assign tx_pop = tx_take;
  assign rx_free = RX_FULL - r.rx_cnt;
  assign usb_rpt_valid = (r.fwd_left != '0);
  assign usb_rpt_data = rx_mem[r.rx_rd];
  assign usb_rpt_last = (r.fwd_left == (RW + 1)'(1));

  // Send input exists only on the tenth pin; without it sending is free.
  assign send_on = (aux_func[`USAF_TENTH_PIN] == FN_SEND) ? r.sync[`USAF_TENTH_PIN] : 1'b1;
  assign send_rise = (aux_func[`USAF_TENTH_PIN] == FN_SEND) && send_on && !r.send_prev;
  assign intr_rise = (aux_func[`USAF_TENTH_PIN] == FN_INTR)
                     && r.sync[`USAF_TENTH_PIN] && !r.intr_prev;

  // The sense input may sit on any pin; any pin so set reports self power.
  always_comb begin
    self_sense = 1'b0;
    for (int i = 0; i < NP; i++) begin
      if (aux_func[i] == FN_SELF_PWR) begin
        self_sense = self_sense | r.sync[i];
      end
    end
  end

  // Per-pin function multiplexer; the first pin never drives an output.
  for (genvar i = 0; i < NP; i++) begin : g_pin
    always_comb begin
      pin_en[i] = (i != `USAF_FIRST_PIN);
      unique case (aux_func[i])
        FN_TX_IND:      pin_val[i] = tx_ind;
        FN_RX_IND:      pin_val[i] = rx_ind;
        FN_TXRX_IND:    pin_val[i] = txrx_ind;
        FN_CONFIGURED:  pin_val[i] = r.cfg;
        FN_SUSPEND_N:   pin_val[i] = r.susp_n;
        FN_HOST_RDY:    pin_val[i] = r.hrdy;
        FN_LOW_PWR:     pin_val[i] = r.lowp;
        FN_ASG_N:       pin_val[i] = r.asg_n;
        FN_RX_NOT_FULL: pin_val[i] = r.not_full;
        FN_TX_EMPTY:    pin_val[i] = (r.tx_cnt == '0);
        FN_DOUT:        pin_val[i] = r.gpo[i];
        default: begin
          // Inputs and unused pins float.
          pin_val[i] = 1'b0;
          pin_en[i] = 1'b0;
        end
      endcase
    end
  end

  // Next-state logic of buffers, status, forwarding and settings.
  always_comb begin
    n = r;
    n.meta = aux_pin_i;
    n.sync = r.meta;
    n.pin_o = pin_val;
    n.pin_oe = pin_en;
    n.send_prev = send_on;
    n.intr_prev = r.sync[`USAF_TENTH_PIN];
    n.int_rpt = send_rise | intr_rise;
    // Status encoding: sleep keeps configured, raises low power.
    n.cfg = usb_configured;
    n.susp_n = !usb_suspended;
    n.asg_n = !(usb_configured && !usb_suspended);
    n.lowp = !usb_configured || usb_suspended || unpowered_hub_state;
    n.hrdy = usb_configured && !usb_suspended && host_app_running;
    // Receive store toward the host.
    if (rx_push) begin
      n.rx_wr = r.rx_wr + 1'b1;
    end
    if (rx_pop) begin
      n.rx_rd = r.rx_rd + 1'b1;
    end
    n.rx_cnt = r.rx_cnt + (RW + 1)'(rx_push) - (RW + 1)'(rx_pop);
    // Hysteresis on the free space, judged after this cycle's moves.
    if ((RX_FULL - n.rx_cnt) <= LOW_W) begin
      n.not_full = 1'b0;
    end else if ((RX_FULL - n.rx_cnt) >= HIGH_W) begin
      n.not_full = 1'b1;
    end
    // Transmit store toward the master.
    if (tx_push) begin
      n.tx_wr = r.tx_wr + 1'b1;
    end
    if (tx_pop) begin
      n.tx_rd = r.tx_rd + 1'b1;
    end
    n.tx_cnt = r.tx_cnt + (TW + 1)'(tx_push) - (TW + 1)'(tx_pop);
    // Forwarding: a report starts only while send is active.
    n.pend = r.pend | frame_end | send_rise;
    if (rx_pop) begin
      n.fwd_left = r.fwd_left - 1'b1;
    end
    if (r.fwd_left == '0 && send_on && r.rx_cnt != '0
        && (r.rx_cnt >= RPT_N || r.pend)) begin
      n.fwd_left = (r.rx_cnt >= RPT_N) ? RPT_N : r.rx_cnt;
      // A flush outlives this report while more held bytes wait behind it.
      n.pend = frame_end | send_rise | (r.pend && (r.rx_cnt > RPT_N));
    end else if (r.fwd_left == '0 && r.rx_cnt == '0 && !rx_push) begin
      // Nothing to send; a stale deselect must not flush a later byte.
      n.pend = send_rise;
    end
    // General outputs follow the set-pin command.
    if (gpo_set_valid && gpo_set_idx < 4'(NP)) begin
      n.gpo[gpo_set_idx] = gpo_set_level;
    end
    // Setting writes; the lock makes them all inert.
    if (nv_wr_valid && !r.lock) begin
      unique case (nv_wr_sel)
        NV_LOCK:    n.lock = nv_wr_data[0];
        NV_MODE:    n.mode = nv_wr_data[1:0];
        NV_FILLER:  n.filler = nv_wr_data;
        NV_PWR_SRC: n.psrc = (nv_wr_data[1:0] == 2'h3) ? PWR_BOTH
                             : usaf_pwr_src_t'(nv_wr_data[1:0]);
        NV_MAX_PWR: n.maxp = nv_wr_data;
        default:    n.lock = r.lock;
      endcase
    end
  end

  // State register; settings and outputs take their documented defaults.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.not_full <= 1'b1;
      r.susp_n <= 1'b1;
      r.lowp <= 1'b1;
      r.asg_n <= 1'b1;
      r.send_prev <= 1'b1;
      r.intr_prev <= 1'b1;
      r.mode <= `USAF_MODE_RST;
      r.filler <= `USAF_FILLER_RST;
      r.maxp <= `USAF_MAXP_RST;
      r.psrc <= PWR_BUS;
    end else begin
      r <= n;
    end
  end

  // Byte stores carry no reset; the pointers decide what is valid.
  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[r.rx_wr] <= rx_byte;
    end
    if (tx_push) begin
      tx_mem[r.tx_wr] <= host_data;
    end
  end

  assign aux_pin_o = r.pin_o;
  assign aux_pin_oe = r.pin_oe;
  assign pin_levels = r.sync;
  assign int_report = r.int_rpt;
  assign write_lock = r.lock;
  assign spi_mode = r.mode;
  assign filler_byte = r.filler;
  assign power_src = r.psrc;
  assign max_bus_power = r.maxp;
  assign self_power_rpt = (r.psrc == PWR_BOTH) ? self_sense : (r.psrc == PWR_SELF);

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic int_rpt_seen;  // Interrupt report as the pin side sees it.
  assign int_rpt_seen = int_report;
  sequence s_send_edge;
    send_rise ##1 int_rpt_seen;
  endsequence

  chk_drop_full: assert property (rx_valid && r.rx_cnt == RX_FULL && !rx_pop
    |=> r.rx_cnt == RX_FULL && $stable(r.rx_wr)) else $error("full buffer took a byte");
  chk_notfull_low: assert property (rx_free <= LOW_W |-> !r.not_full)
    else $error("not-full high with little space");
  chk_notfull_high: assert property (rx_free >= HIGH_W |-> r.not_full)
    else $error("not-full low with ample space");
  chk_empty_drop: assert property (tx_push && !tx_pop |=> r.tx_cnt != '0)
    else $error("empty flag stayed high after entry");
  chk_lock_hold: assert property (r.lock && nv_wr_valid |=> $stable(r.filler) && r.lock)
    else $error("locked setting changed");
  chk_go_state: assert property (##1 (r.asg_n == !($past(usb_configured) && !$past(usb_suspended))))
    else $error("go output wrong for state");
  chk_send_hold: assert property (r.fwd_left == '0 && !send_on |=> r.fwd_left == '0)
    else $error("report started while send inactive");
  chk_send_int: assert property (send_rise |-> s_send_edge)
    else $error("send edge gave no interrupt");
  chk_rpt_size: assert property (r.fwd_left <= RPT_N)
    else $error("report longer than allowed");
  chk_sleep_code: assert property (usb_configured && usb_suspended
    |=> r.cfg && !r.susp_n && r.lowp && r.asg_n && !r.hrdy)
    else $error("sleep status code wrong");
endmodule : usaf_top

// >>> pkg/usaf_map.svh
// Purpose: Named constants for the auxiliary-pin and flow-control block.
// Assumes: Included by the package and by the top module.
// Notes:   Definitions only; guarded against double inclusion.
`ifndef USAF_MAP_SVH
`define USAF_MAP_SVH
`define USAF_CLK_HZ       40000000   // System clock rate in hertz.
`define USAF_IND_MS       100        // Indicator pulse length in milliseconds.
`define USAF_RX_DEPTH     128        // Bytes held toward the host.
`define USAF_TX_DEPTH     128        // Bytes held toward the serial master.
`define USAF_LOW_WATER    16         // Free bytes at which not-full drops.
`define USAF_HIGH_WATER   32         // Free bytes at which not-full returns.
`define USAF_REPORT_BYTES 63         // Bytes per report to the host.
`define USAF_NPINS        11         // Number of auxiliary pins.
`define USAF_FIRST_PIN    0          // Pin that may carry no output.
`define USAF_TENTH_PIN    9          // Only pin for send and interrupt inputs.
`define USAF_FILLER_RST   8'hff      // Filler byte after reset.
`define USAF_MODE_RST     2'h3       // Clock polarity and phase after reset.
`define USAF_MAXP_RST     8'h32      // Max bus power in 2 mA units (100 mA).
`endif

// >>> pkg/usaf_pkg.sv
// Purpose: Shared types of the auxiliary-pin and flow-control block.
// Assumes: The constant header sits beside this file.
// Notes:   Encodings are free choices, except power source: its setting write casts raw values.
`include "usaf_map.svh"
package usaf_pkg;
  // Function that software assigns to one auxiliary pin.
  typedef enum logic [3:0] {
    FN_NONE, FN_TX_IND, FN_RX_IND, FN_TXRX_IND, FN_CONFIGURED, FN_SUSPEND_N,
    FN_HOST_RDY, FN_LOW_PWR, FN_ASG_N, FN_RX_NOT_FULL, FN_TX_EMPTY, FN_SEND,
    FN_DIN, FN_DOUT, FN_INTR, FN_SELF_PWR
  } usaf_func_t;
  // Where the product takes its power from.
  typedef enum logic [1:0] {PWR_BUS, PWR_SELF, PWR_BOTH} usaf_pwr_src_t;
  // Which non-volatile setting a write addresses.
  typedef enum logic [2:0] {NV_LOCK, NV_MODE, NV_FILLER, NV_PWR_SRC, NV_MAX_PWR} usaf_nv_sel_t;
endpackage : usaf_pkg

// >>> hdl/usaf_ind_pulse.sv
// Purpose: Retriggerable pulse stretcher for one activity indicator.
// Assumes: trig is a one-cycle pulse from logic on clk.
// Notes:   Each trigger restarts the full pulse length.
`timescale 1ns/10ps
module usaf_ind_pulse #(
  parameter int CYCLES = 4000000
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic trig,
  output logic      ind
);
  import usaf_pkg::*;
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);

  // Whole state of the stretcher.
  typedef struct packed {
    logic [W-1:0] cnt;  // Cycles left in the pulse.
    logic         ind;  // Registered indicator level.
  } usaf_pls_t;
  usaf_pls_t r, n;

  // Reload on every event, otherwise count down to zero.
  always_comb begin
    n = r;
    if (trig) begin
      n.cnt = LOAD;
    end else if (r.cnt != '0) begin
      n.cnt = r.cnt - 1'b1;
    end
    n.ind = (n.cnt != '0);
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign ind = r.ind;

  // The pulse must still be on eight cycles after a trigger.
  chk_pulse_len: assert property (@(posedge clk) disable iff (sys_rst)
    trig |=> ind [*8]) else $error("indicator pulse ended early");
endmodule : usaf_ind_pulse

// >>> hdl/usaf_spi_slave.sv
// Purpose: Serial slave port, all four clock modes, MSB first bytes.
// Assumes: sck is far slower than clk, so every pin edge is seen.
// Notes:   Pins pass two flip-flops; edges are found on the synced copy.
`timescale 1ns/10ps
module usaf_spi_slave (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       sck_pin,
  input  wire logic       mosi_pin,
  input  wire logic       ss_n_pin,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       tx_have,
  input  wire logic [7:0] tx_byte,
  input  wire logic [7:0] filler,
  output logic            tx_take,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            frame_end,
  output logic            miso_o,
  output logic            miso_oe
);
  import usaf_pkg::*;

  // Whole state of the port.
  typedef struct packed {
    logic sck_m, sck_s, sck_d, mosi_m, mosi_s, ss_m, ss_s, ss_d;
    logic [7:0] sh;     // Outgoing byte.
    logic [7:0] rsh;    // Incoming byte.
    logic [2:0] bits;   // Bits sampled in this byte.
    logic       skip;   // Next shift edge only presents the loaded MSB.
    logic       take, rx_valid, fend, miso, oe;
    logic [7:0] rx_byte;
  } usaf_spi_t;
  usaf_spi_t r, n;
  logic rise, fall, samp, shft, start, ld, first;

  assign rise  = r.sck_s & ~r.sck_d;
  assign fall  = ~r.sck_s & r.sck_d;
  assign samp  = cpha ? (cpol ? rise : fall) : (cpol ? fall : rise);
  assign shft  = cpha ? (cpol ? fall : rise) : (cpol ? rise : fall);
  assign start = ~r.ss_s & r.ss_d;

  // Sampling, shifting and byte loading.
  always_comb begin
    n = r;
    ld = 1'b0;
    first = 1'b0;
    n.sck_m = sck_pin;
    n.sck_s = r.sck_m;
    n.sck_d = r.sck_s;
    n.mosi_m = mosi_pin;
    n.mosi_s = r.mosi_m;
    n.ss_m = ss_n_pin;
    n.ss_s = r.ss_m;
    n.ss_d = r.ss_s;
    n.take = 1'b0;
    n.rx_valid = 1'b0;
    n.fend = r.ss_s & ~r.ss_d;
    if (start) begin
      n.bits = '0;
      ld = 1'b1;
      first = 1'b1;
    end else if (!r.ss_s) begin
      if (samp) begin
        n.rsh = {r.rsh[6:0], r.mosi_s};
        n.bits = r.bits + 1'b1;
        if (r.bits == 3'h7) begin
          n.rx_valid = 1'b1;
          n.rx_byte = {r.rsh[6:0], r.mosi_s};
          ld = 1'b1;
        end
      end else if (shft) begin
        if (r.skip) begin
          n.skip = 1'b0;
        end else begin
          n.sh = {r.sh[6:0], 1'b0};
        end
      end
    end
    // A loaded filler byte stays even if host data lands right after.
    if (ld) begin
      n.sh = tx_have ? tx_byte : filler;
      n.take = tx_have;
      n.skip = cpha | ~first;
    end
    n.miso = n.sh[7];
    n.oe = ~r.ss_s;
  end

  // State register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      r <= '0;
      r.sck_m <= 1'b1;
      r.sck_s <= 1'b1;
      r.sck_d <= 1'b1;
      r.ss_m <= 1'b1;
      r.ss_s <= 1'b1;
      r.ss_d <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign tx_take = r.take;
  assign rx_valid = r.rx_valid;
  assign rx_byte = r.rx_byte;
  assign frame_end = r.fend;
  assign miso_o = r.miso;
  assign miso_oe = r.oe;
endmodule : usaf_spi_slave

// >>> verification/usaf_spi_master.sv
// Purpose: Serial master model for the slave port, clock mode 3.
// Assumes: Clock idles high; mosi moves on falling sck, miso is read on rising.
// Notes:   Period 200 ns; the clock stands still between frames.
`timescale 1ns/10ps
module usaf_spi_master (
  output logic      sck_pin,
  output logic      mosi_pin,
  output logic      ss_n_pin,
  input  wire logic miso_o
);
  // Idle levels: deselected, clock high.
  initial begin
    sck_pin = 1'b1;
    mosi_pin = 1'b0;
    ss_n_pin = 1'b1;
  end
  // Opens or closes a frame, with setup time before the next edge.
  task sel(input logic on);
    ss_n_pin = ~on;
    #400;
  endtask : sel
  // One byte each way, most significant bit first.
  task xfer(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--) begin
      sck_pin = 1'b0;
      mosi_pin = d[i];
      #100;
      sck_pin = 1'b1;
      q[i] = miso_o;
      #100;
    end
    // Hold time over, so the line no longer shows the last bit.
    mosi_pin = ~mosi_pin;
  endtask : xfer
endmodule : usaf_spi_master

// >>> verification/test_usaf_top.sv
// Purpose: Self-checking bench for settings, status pins and report flow.
// Assumes: Pin 9 carries the send input; short indicator count.
// Notes:   Report bytes are collected as the host side takes them.
`timescale 1ns/10ps
module test_usaf_top;
  import usaf_pkg::*;
  logic clk, sys_rst, sck_pin, mosi_pin, ss_n_pin, miso_o, miso_oe, usb_rpt_valid;
  logic usb_rpt_ready, usb_configured, usb_suspended, unpowered_hub_state;
  logic host_app_running, int_report, nv_wr_valid, write_lock;
  logic [7:0] usb_rpt_data, nv_wr_data, filler_byte, max_bus_power, q;
  logic [1:0] spi_mode;
  usaf_pwr_src_t power_src;
  usaf_nv_sel_t nv_wr_sel;
  usaf_func_t [10:0] aux_func;
  logic [10:0] aux_pin_i, aux_pin_o, pin_levels;
  logic host_data_valid, gpo_set_valid, gpo_set_level;
  logic [7:0] host_data;
  logic [3:0] gpo_set_idx;
  logic [8:0] st[4] = '{9'h00e, 9'h147, 9'h133, 9'h1cd};
  logic [7:0] rq[$];
  int fails, total_checks, cyc, n_int;
  usaf_top #(.IND_CYCLES(20)) usaf_top_inst (.clk, .sys_rst, .sck_pin, .mosi_pin,
    .ss_n_pin, .miso_o, .miso_oe, .host_data_valid, .host_data,
    .host_data_ready(), .usb_rpt_valid, .usb_rpt_data, .usb_rpt_last(), .usb_rpt_ready,
    .usb_configured, .usb_suspended, .unpowered_hub_state, .host_app_running, .aux_func,
    .aux_pin_i, .aux_pin_o, .aux_pin_oe(), .pin_levels, .gpo_set_valid,
    .gpo_set_idx, .gpo_set_level, .int_report, .nv_wr_valid, .nv_wr_sel,
    .nv_wr_data, .write_lock, .spi_mode, .filler_byte, .power_src, .max_bus_power,
    .self_power_rpt());
  usaf_spi_master spi_master_inst (.sck_pin, .mosi_pin, .ss_n_pin, .miso_o);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Collects report bytes and interrupts; cuts a hang short.
  always @(posedge clk) begin
    cyc++;
    if (usb_rpt_valid === 1'b1) rq.push_back(usb_rpt_data);
    if (int_report === 1'b1) n_int++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  task chk(input string n, input logic [7:0] e, input logic [7:0] s);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task nv(input usaf_nv_sel_t s, input logic [7:0] d);
    nv_wr_sel = s;
    nv_wr_data = d;
    nv_wr_valid = 1'b1;
    tick(1);
    nv_wr_valid = 1'b0;
    tick(1);
  endtask : nv
  // Reset defaults, then a write that the lock must ignore.
  task t_settings;
    chk("filler", 8'hff, filler_byte);
    chk("maxpwr", 8'h32, max_bus_power);
    chk("mode", 8'h03, {6'h0, spi_mode});
    chk("src", {6'h0, PWR_BUS}, {6'h0, power_src});
    nv(NV_FILLER, 8'h5a);
    nv(NV_LOCK, 8'h01);
    nv(NV_FILLER, 8'h00);
    chk("locked", 8'h5a, filler_byte);
    chk("lockbit", 8'h01, {7'h0, write_lock});
    chk("gpo0", 8'h00, {7'h0, aux_pin_o[7]});
    {gpo_set_idx, gpo_set_level, gpo_set_valid} = {4'h7, 2'b11};
    tick(1);
    gpo_set_valid = 1'b0;
    tick(2);
    chk("gpo1", 8'h01, {7'h0, aux_pin_o[7]});
    $display("settings done");
  endtask : t_settings
  // Each USB state row against the status pin table.
  task t_status;
    foreach (st[i]) begin
      {usb_configured, usb_suspended, unpowered_hub_state, host_app_running} = st[i][8:5];
      tick(4);
      chk("status", {3'h0, st[i][4:0]}, {3'h0, aux_pin_o[5:1]});
    end
    $display("status done");
  endtask : t_status
  // Held while send is low, released on its rise, then a two-byte frame.
  task t_flow;
    chk("room", 8'h01, {7'h0, aux_pin_o[10]});
    spi_master_inst.sel(1'b1);
    spi_master_inst.xfer(8'hc3, q);
    spi_master_inst.sel(1'b0);
    chk("miso", 8'h5a, q);
    tick(40);
    chk("held", 8'h00, 8'(rq.size()));
    aux_pin_i[9] = 1'b1;
    tick(10);
    chk("txind", 8'h01, {7'h0, aux_pin_o[6]});
    chk("getpin", 8'h01, {7'h0, pin_levels[9]});
    tick(30);
    chk("sent", 8'hc3, rq[0]);
    chk("ints", 8'h01, 8'(n_int));
    spi_master_inst.sel(1'b1);
    spi_master_inst.xfer(8'h12, q);
    spi_master_inst.xfer(8'hb4, q);
    spi_master_inst.sel(1'b0);
    tick(40);
    chk("count", 8'h03, 8'(rq.size()));
    chk("b1", 8'h12, rq[1]);
    chk("b2", 8'hb4, rq[2]);
    chk("indoff", 8'h00, {7'h0, aux_pin_o[6]});
    $display("flow done");
  endtask : t_flow
  // A host byte clears the empty pin and is the next byte the master reads.
  task t_host;
    chk("empty", 8'h01, {7'h0, aux_pin_o[8]});
    {host_data, host_data_valid} = {8'h3c, 1'b1};
    tick(1);
    host_data_valid = 1'b0;
    tick(2);
    chk("filled", 8'h00, {7'h0, aux_pin_o[8]});
    spi_master_inst.sel(1'b1);
    spi_master_inst.xfer(8'h77, q);
    chk("txdata", 8'h3c, q);
    chk("empty2", 8'h01, {7'h0, aux_pin_o[8]});
    spi_master_inst.sel(1'b0);
    $display("host done");
  endtask : t_host
  // Overfill while send is low on purpose; the last two bytes must be lost.
  task t_full;
    int base;
    aux_pin_i[9] = 1'b0;
    tick(4);
    spi_master_inst.sel(1'b1);
    for (int i = 0; i < 130; i++) spi_master_inst.xfer((i < 128) ? 8'ha5 : 8'h3c, q);
    spi_master_inst.sel(1'b0);
    chk("nofree", 8'h00, {7'h0, aux_pin_o[10]});
    base = rq.size();
    aux_pin_i[9] = 1'b1;
    tick(300);
    chk("kept", 8'h80, 8'(rq.size() - base));
    chk("last", 8'ha5, rq[rq.size() - 1]);
    chk("ints2", 8'h02, 8'(n_int));
    chk("free", 8'h01, {7'h0, aux_pin_o[10]});
    $display("full done");
  endtask : t_full
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_of_test
  initial begin
    aux_func = '{FN_RX_NOT_FULL, FN_SEND, FN_TX_EMPTY, FN_DOUT, FN_TX_IND, FN_HOST_RDY,
                 FN_ASG_N, FN_LOW_PWR, FN_SUSPEND_N, FN_CONFIGURED, FN_NONE};
    {usb_configured, usb_suspended, unpowered_hub_state, host_app_running} = 4'h0;
    {host_data_valid, gpo_set_valid, aux_pin_i, nv_wr_valid, nv_wr_data, nv_wr_sel,
     usb_rpt_ready} = {22'h0, NV_LOCK, 1'b1};
    sys_rst = 1'b1;
    tick(4);
    sys_rst = 1'b0;
    tick(2);
    t_settings();
    t_status();
    t_flow();
    t_host();
    t_full();
    end_of_test();
  end
endmodule : test_usaf_top
